// *** verilog/core_clock_and_slow_idle.sv ***
// Processor cycle tick generation with standard and slow idle states.
//
// Function
// - Each edge of the oscillator input yields one cycle: double its rate.
// - The cycle tick times everything; one instruction step per run cycle.
// - Cycle clock output pulses once per processor cycle while enabled.
// - A disable input turns the cycle clock output off.
// - Slow idle divisor is 16, 32, 64 or 128 and divides the cycle rate.
// - Slow idle keeps all logic but instruction steps running at the reduced rate.
// - Serial, output and timer ticks are reduced by the same divisor.
// - Idle without a divisor enters standard idle with no slowing.
// - Slow idle wakes on interrupt within the divisor's count of cycles.
// - Standard idle wakes within one cycle of an enabled interrupt.
`timescale 1ns/100ps
module core_clock_and_slow_idle
(
    input wire logic clk_i,                      // System clock, 200 MHz.
    input wire logic rst_b_i,                    // Async reset, active low.
    input wire logic osc_input_i,                // Sampled oscillator level.
    input wire logic cycle_clock_out_disable_i,  // High turns output off.
    input wire logic idle_req_i,                 // Idle instruction pulse.
    input wire logic idle_div_given_i,           // Idle carries a divisor.
    input wire logic [1:0] idle_div_sel_i,       // 16/32/64/128 code.
    input wire logic wake_irq_i,                 // Enabled interrupt level.
    output logic core_tick_o,                    // Core cycle tick pulse.
    output logic instr_step_o,                   // Instruction step pulse.
    output logic serial_tick_o,                  // Serial clock base tick.
    output logic timer_tick_o,                   // Timer base tick.
    output logic cycle_clock_output_o,           // Cycle clock output.
    output logic idle_o,                         // In standard idle.
    output logic slow_idle_o                     // In slow idle.
);

    core_clock_pkg::idle_state_e state_reg;
    core_clock_pkg::idle_state_e state_next;
    logic osc_prev_reg;
    logic osc_prev_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic wake_pend_reg;
    logic wake_pend_next;
    logic raw_tick;
    logic div_tick;
    logic div_en;

    logic core_tick_reg;
    logic core_tick_next;
    logic instr_step_reg;
    logic instr_step_next;
    logic cycle_clock_reg;
    logic cycle_clock_next;
    logic idle_reg;
    logic idle_next;
    logic slow_reg;
    logic slow_next;

    // ------------------------------------------------------------
    // Cycle tick from both oscillator edges
    // ------------------------------------------------------------
    always_comb
    begin
        osc_prev_next = osc_input_i;
        raw_tick = osc_input_i ^ osc_prev_reg;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= osc_prev_next;
        end
    end

    // ------------------------------------------------------------
    // Divider for slow idle
    // ------------------------------------------------------------
    assign div_en = (state_reg == core_clock_pkg::ST_SLOW);

    slow_idle_divider u_div
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(raw_tick),
        .enable_i(div_en),
        .sel_i(sel_reg),
        .tick_o(div_tick)
    );

    // ------------------------------------------------------------
    // Idle state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        sel_next = sel_reg;
        wake_pend_next = wake_pend_reg;
        case (state_reg)
            core_clock_pkg::ST_RUN:
            begin
                wake_pend_next = 1'b0;
                if (idle_req_i)
                begin
                    if (idle_div_given_i)
                    begin
                        state_next = core_clock_pkg::ST_SLOW;
                        sel_next = idle_div_sel_i;
                    end
                    else
                    begin
                        state_next = core_clock_pkg::ST_IDLE;
                    end
                end
            end
            core_clock_pkg::ST_IDLE:
            begin
                if (wake_irq_i && raw_tick)
                begin
                    state_next = core_clock_pkg::ST_RUN;
                end
            end
            core_clock_pkg::ST_SLOW:
            begin
                // An interrupt is held until the next divided cycle.
                if ((wake_irq_i || wake_pend_reg) && div_tick)
                begin
                    state_next = core_clock_pkg::ST_RUN;
                    wake_pend_next = 1'b0;
                end
                else if (wake_irq_i)
                begin
                    wake_pend_next = 1'b1;
                end
            end
            default:
            begin
                state_next = core_clock_pkg::ST_RUN;
                wake_pend_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= core_clock_pkg::ST_RUN;
            sel_reg <= core_clock_pkg::SEL_DIV16;
            wake_pend_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            wake_pend_reg <= wake_pend_next;
        end
    end

    // ------------------------------------------------------------
    // Registered tick and status outputs
    // ------------------------------------------------------------
    always_comb
    begin
        // Idle states keep ticking; only instruction steps stop.
        core_tick_next = div_tick;
        instr_step_next = div_tick && (state_reg == core_clock_pkg::ST_RUN);
        cycle_clock_next = div_tick && !cycle_clock_out_disable_i;
        idle_next = (state_next == core_clock_pkg::ST_IDLE);
        slow_next = (state_next == core_clock_pkg::ST_SLOW);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            core_tick_reg <= 1'b0;
            instr_step_reg <= 1'b0;
            cycle_clock_reg <= 1'b0;
            idle_reg <= 1'b0;
            slow_reg <= 1'b0;
        end
        else
        begin
            core_tick_reg <= core_tick_next;
            instr_step_reg <= instr_step_next;
            cycle_clock_reg <= cycle_clock_next;
            idle_reg <= idle_next;
            slow_reg <= slow_next;
        end
    end

    assign core_tick_o = core_tick_reg;
    assign instr_step_o = instr_step_reg;
    // Serial and timer bases share the core tick so ratios never slip.
    assign serial_tick_o = core_tick_reg;
    assign timer_tick_o = core_tick_reg;
    assign cycle_clock_output_o = cycle_clock_reg;
    assign idle_o = idle_reg;
    assign slow_idle_o = slow_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_slow_wake_cause;
        state_reg == core_clock_pkg::ST_SLOW &&
        (wake_irq_i || wake_pend_reg) && div_tick;
    endsequence

    sequence s_back_to_run;
        state_reg == core_clock_pkg::ST_RUN && core_tick_o && !slow_idle_o;
    endsequence

    a_edge_gives_tick: assert property (
        state_reg != core_clock_pkg::ST_SLOW && osc_input_i != osc_prev_reg
        |=> core_tick_o)
        else $error("Oscillator edge did not yield a cycle tick.");

    a_step_in_run: assert property (
        instr_step_o |-> core_tick_o && $past(state_reg) ==
        core_clock_pkg::ST_RUN)
        else $error("Instruction step outside a run cycle.");

    a_cycle_clock_output_pulse: assert property (
        cycle_clock_output_o ==
        (core_tick_o && !$past(cycle_clock_out_disable_i)))
        else $error("Cycle clock output does not follow the tick.");

    a_cycle_clock_output_off: assert property (
        cycle_clock_out_disable_i[*2] |=> !cycle_clock_output_o)
        else $error("Cycle clock output active while disabled.");

    a_same_ratio: assert property (
        core_tick_o |-> serial_tick_o && timer_tick_o)
        else $error("Derived ticks differ from the core tick.");

    a_std_idle: assert property (
        state_reg == core_clock_pkg::ST_RUN && idle_req_i &&
        !idle_div_given_i |=> idle_o && !slow_idle_o)
        else $error("Idle without divisor did not enter standard idle.");

    a_slow_entry: assert property (
        state_reg == core_clock_pkg::ST_RUN && idle_req_i &&
        idle_div_given_i |=> slow_idle_o ##1 div_en)
        else $error("Idle with divisor did not enter slow idle.");

    a_idle_wake: assert property (
        state_reg == core_clock_pkg::ST_IDLE && wake_irq_i &&
        osc_input_i != osc_prev_reg |=> !idle_o)
        else $error("Standard idle did not wake on the next cycle.");

    a_slow_wake: assert property (
        s_slow_wake_cause |=> s_back_to_run)
        else $error("Slow idle did not wake on the divided tick.");

    a_restore: assert property (
        $fell(slow_idle_o) |-> state_reg == core_clock_pkg::ST_RUN)
        else $error("Full rate not restored on leaving slow idle.");

endmodule

// *** shared/core_clock_pkg.sv ***
// Constants and types shared by the core clock and slow idle logic.
package core_clock_pkg;

    // ------------------------------------------------------------
    // Divisor selection and counter layout
    // ------------------------------------------------------------
    localparam int SEL_W = 2;
    localparam int CNT_W = 7;
    localparam logic [1:0] SEL_DIV16 = 2'h0;
    localparam logic [1:0] SEL_DIV32 = 2'h1;
    localparam logic [1:0] SEL_DIV64 = 2'h2;
    localparam logic [1:0] SEL_DIV128 = 2'h3;
    localparam logic [6:0] LIMIT_DIV16 = 7'h0F;
    localparam logic [6:0] LIMIT_DIV32 = 7'h1F;
    localparam logic [6:0] LIMIT_DIV64 = 7'h3F;
    localparam logic [6:0] LIMIT_DIV128 = 7'h7F;
    localparam logic [6:0] CNT_RESET = 7'h00;
    localparam logic [6:0] CNT_ONE = 7'h01;

    // ------------------------------------------------------------
    // Idle state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_RUN = 2'h0,
        ST_IDLE = 2'h1,
        ST_SLOW = 2'h2
    } idle_state_e;

endpackage

// *** verilog/slow_idle_divider.sv ***
// Tick divider that passes one tick in every 16, 32, 64 or 128.
`timescale 1ns/100ps
module slow_idle_divider
(
    input wire logic clk_i,         // System clock.
    input wire logic rst_b_i,       // Asynchronous reset, active low.
    input wire logic tick_i,        // Undivided cycle tick.
    input wire logic enable_i,      // High while dividing.
    input wire logic [1:0] sel_i,   // Divisor code.
    output logic tick_o             // Divided tick, combinational.
);

    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [6:0] limit;

    // ------------------------------------------------------------
    // Divisor decode and counter
    // ------------------------------------------------------------
    always_comb
    begin
        case (sel_i)
            core_clock_pkg::SEL_DIV16: limit = core_clock_pkg::LIMIT_DIV16;
            core_clock_pkg::SEL_DIV32: limit = core_clock_pkg::LIMIT_DIV32;
            core_clock_pkg::SEL_DIV64: limit = core_clock_pkg::LIMIT_DIV64;
            core_clock_pkg::SEL_DIV128: limit = core_clock_pkg::LIMIT_DIV128;
            default: limit = core_clock_pkg::LIMIT_DIV16;
        endcase
    end

    always_comb
    begin
        cnt_next = cnt_reg;
        tick_o = 1'b0;
        if (!enable_i)
        begin
            // Leaving the divided mode restarts the count at once.
            cnt_next = core_clock_pkg::CNT_RESET;
            tick_o = tick_i;
        end
        else if (tick_i)
        begin
            if (cnt_reg == limit)
            begin
                cnt_next = core_clock_pkg::CNT_RESET;
                tick_o = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + core_clock_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg <= core_clock_pkg::CNT_RESET;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_div_limit: assert property (
        enable_i && tick_i && cnt_reg != limit |-> !tick_o ##1
        cnt_reg == $past(cnt_reg) + core_clock_pkg::CNT_ONE)
        else $error("Divided tick issued before the divisor count.");

    a_div_restart: assert property (
        !enable_i |=> cnt_reg == core_clock_pkg::CNT_RESET)
        else $error("Divider count not cleared outside slow idle.");

endmodule

// *** verification/osc_source_model.sv ***
// Oscillator source model that drives the block's clock input pin.
`timescale 1ns/100ps
module osc_source_model
(
    input wire logic clk_i,         // Bench clock.
    input wire logic [3:0] half_i,  // Half period in clock cycles.
    output logic osc_o              // Oscillator level.
);
    int cnt;

    initial
    begin
        osc_o = 1'b0;
        cnt = 0;
    end

    // The source never halts and keeps one steady rate for the whole run.
    always @(negedge clk_i)
    begin
        if (cnt + 1 >= int'(half_i))
        begin
            cnt = 0;
            osc_o <= ~osc_o;
        end
        else
            cnt = cnt + 1;
    end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the core clock and slow idle block.
`timescale 1ns/100ps
module testbench;
    logic clk_i;
    logic rst_b_i;
    logic osc_input_i;
    logic cycle_clock_out_disable_i;
    logic idle_req_i;
    logic idle_div_given_i;
    logic [1:0] idle_div_sel_i;
    logic wake_irq_i;
    logic core_tick_o;
    logic instr_step_o;
    logic serial_tick_o;
    logic timer_tick_o;
    logic cycle_clock_output_o;
    logic idle_o;
    logic slow_idle_o;
    logic [3:0] half;
    logic osc_h1;
    logic osc_h2;
    logic dis_h1;
    logic tick_exp;
    logic saw_edge;
    int seed;
    int failures;
    int check_count;
    int mode;
    int edge_cnt;
    int tick_cnt;
    int cco_cnt;
    int n;

    core_clock_and_slow_idle core_clock_and_slow_idle_i
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .osc_input_i(osc_input_i),
        .cycle_clock_out_disable_i(cycle_clock_out_disable_i),
        .idle_req_i(idle_req_i),
        .idle_div_given_i(idle_div_given_i),
        .idle_div_sel_i(idle_div_sel_i),
        .wake_irq_i(wake_irq_i),
        .core_tick_o(core_tick_o),
        .instr_step_o(instr_step_o),
        .serial_tick_o(serial_tick_o),
        .timer_tick_o(timer_tick_o),
        .cycle_clock_output_o(cycle_clock_output_o),
        .idle_o(idle_o),
        .slow_idle_o(slow_idle_o)
    );

    osc_source_model osc_source_model_i
    (
        .clk_i(clk_i),
        .half_i(half),
        .osc_o(osc_input_i)
    );

    initial
        clk_i = 1'b0;
    always #2.5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Checking tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic limit_hit(input string what);
        failures++;
        $display("FAIL %s expected done seen timeout", what);
        test_done();
    endtask

    function automatic logic [15:0] slow_ticks(input int edges, input int d);
        return 16'(edges / d);
    endfunction

    // Each posedge: a tick follows every oscillator change one clock later.
    always @(posedge clk_i)
    begin
        osc_h1 <= rst_b_i ? osc_input_i : 1'b0;
        osc_h2 <= osc_h1;
        dis_h1 <= cycle_clock_out_disable_i;
        tick_exp = osc_h1 ^ osc_h2;
        saw_edge = rst_b_i && (osc_input_i !== osc_h1);
        if (saw_edge)
            edge_cnt++;
        if (core_tick_o === 1'b1)
            tick_cnt++;
        if (cycle_clock_output_o === 1'b1)
            cco_cnt++;
        if (rst_b_i)
        begin
            check("serial_tick", serial_tick_o, core_tick_o);
            check("timer_tick", timer_tick_o, core_tick_o);
        end
        if (mode != 0)
        begin
            check("core_tick", core_tick_o, tick_exp);
            check("instr_step", instr_step_o, tick_exp & (mode == 1));
            check("cycle_out", cycle_clock_output_o, tick_exp & ~dis_h1);
            check("idle", idle_o, mode == 2);
            check("slow_idle", slow_idle_o, 1'b0);
        end
    end

    // ------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------
    task automatic wait_edge();
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(negedge clk_i);
            if (saw_edge)
                break;
        end
        if (i >= 40)
            limit_hit("osc_edge");
    endtask

    task automatic wait_edges(input int target);
        int i;
        for (i = 0; i < 4000 && edge_cnt < target; i++)
            @(negedge clk_i);
        if (i >= 4000)
            limit_hit("edge_count");
    endtask

    task automatic wait_exit();
        int i;
        for (i = 0; i < 1000 && (idle_o !== 1'b0 || slow_idle_o !== 1'b0); i++)
            @(negedge clk_i);
        if (i >= 1000)
            limit_hit("wake");
    endtask

    task automatic go_idle(input logic given, input logic [1:0] sel);
        mode = 0;
        wait_edge();
        idle_req_i = 1'b1;
        idle_div_given_i = given;
        idle_div_sel_i = sel;
        @(negedge clk_i);
        idle_req_i = 1'b0;
        idle_div_given_i = 1'($random(seed));
        idle_div_sel_i = 2'($random(seed));
    endtask

    task automatic run_phase(input int m, input int k);
        mode = m;
        repeat (k)
        begin
            cycle_clock_out_disable_i = 1'($random(seed));
            if (m == 1)
                wake_irq_i = 1'($random(seed));
            @(negedge clk_i);
        end
        wake_irq_i = 1'b0;
        cycle_clock_out_disable_i = 1'b0;
    endtask

    initial
    begin
        seed = 43;
        failures = 0;
        check_count = 0;
        mode = 0;
        edge_cnt = 0;
        tick_cnt = 0;
        cco_cnt = 0;
        half = 4'(3 + {$random(seed)} % 4);
        rst_b_i = 1'b0;
        cycle_clock_out_disable_i = 1'b0;
        idle_req_i = 1'b0;
        idle_div_given_i = 1'b0;
        idle_div_sel_i = 2'h0;
        wake_irq_i = 1'b0;
        repeat (16) @(negedge clk_i);
        check("reset_tick", core_tick_o, 1'b0);
        check("reset_idle", {idle_o, slow_idle_o}, 2'b00);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        run_phase(1, 60);
        go_idle(1'b0, 2'($random(seed)));
        run_phase(2, 10);
        idle_req_i = 1'b1;
        idle_div_given_i = 1'b1;
        @(negedge clk_i);
        idle_req_i = 1'b0;
        run_phase(2, 30);
        mode = 0;
        edge_cnt = 0;
        wake_irq_i = 1'b1;
        wait_exit();
        check("idle_wake_edges", edge_cnt <= 1, 1'b1);
        wake_irq_i = 1'b0;
        // The wake tick itself carries no instruction step.
        @(negedge clk_i);
        run_phase(1, 40);
        for (int s = 0; s < 4; s++)
        begin
            n = 16 << s;
            go_idle(1'b1, 2'(s));
            check("slow_entry", {idle_o, slow_idle_o}, 2'b01);
            edge_cnt = 0;
            tick_cnt = 0;
            cco_cnt = 0;
            wait_edges(3 * n);
            repeat (2) @(negedge clk_i);
            check("slow_ticks", 16'(tick_cnt), slow_ticks(3 * n, n));
            check("slow_cycle_out", 16'(cco_cnt), 16'h0003);
            repeat ({$random(seed)} % (n * int'(half))) @(negedge clk_i);
            edge_cnt = 0;
            // One interrupt at a time, the next only after the wake.
            wake_irq_i = 1'b1;
            wait_exit();
            check("slow_wake_edges", edge_cnt <= n, 1'b1);
            wake_irq_i = 1'b0;
            repeat (2) @(negedge clk_i);
            run_phase(1, 40);
        end
        test_done();
    end
endmodule
